// *** adc_corr_regs.vh ***
`ifndef ADC_CORR_REGS_VH
`define ADC_CORR_REGS_VH
// Overview of operation
// - each channel's stored offset is subtracted from its raw result before the host can see it.
// - each channel result is multiplied by that channel's stored gain factor on every sample.
// - gain scaling works on the already offset-corrected value.
// - each channel other than the zero-phase reference channel 0 is sampled later by its phase setting.
// - data ready follows output buffer loads; with the pulse format set and no reads the buffer loads every second frame.
// - a sync/reset falling edge out of step with the sample period sets the resync flag.
// - sync/reset only checks and realigns the sample period, it never starts a conversion.
// - with the level format, the output frame stays unread and unchanged until every channel word has been read.
// - a write to an isolated-side channel register holds the secondary fail flag until the barrier transfer ends.
// - offset is 24-bit two's complement, bits 23:8 in the upper register and 7:0 in the upper byte of the lower one.
// - gain is a 24-bit unsigned fraction from 0.0 to just below 2.0 and resets to unity.

`define DW 24
`define NCH 3
`define CFG_BASE 6'h09
`define CH_STRIDE 6'h05
`define F_CFG 3'h0
`define F_OFS_UP 3'h1
`define F_OFS_LO 3'h2
`define F_GAIN_UP 3'h3
`define F_GAIN_LO 3'h4
`define PHASE_MSB 15
`define PHASE_LSB 6
`define PHASE_W 10
`define OFFSET_RESET 24'h000000
`define GAIN_RESET 24'h800000
`define GAIN_FRAC 23
`define SAT_POS 24'h7FFFFF
`define SAT_NEG 24'h800000
`define PERIOD_LAST 10'h3FF
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define CLK_PERIOD_NS 20
`define BARRIER_TIME_NS 2000
`define BARRIER_CYCLES ((`BARRIER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_PULSE_NS 200
`define READY_PULSE_CYCLES ((`READY_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** sample_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;
	localparam integer DEPTH_INT = DEPTH;
	localparam [AW:0] FULL_COUNT = DEPTH_INT[AW:0];

	assign in_ready = (count_r != FULL_COUNT);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** adc_result_correction_status.v ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_corr_regs.vh"
module adc_result_correction_status (
	// clock and reset
	input wire clk,
	input wire resetn,
	// converter timing and raw results, channel n in bits 24n+23:24n
	input wire main_clock_in,
	input wire sync_reset_n,
	input wire [71:0] raw_data,
	// configuration write port
	input wire cfg_write,
	input wire [5:0] cfg_addr,
	input wire [15:0] cfg_wdata,
	input wire ready_pulse_format,
	// host data read
	input wire word_read,
	output reg [23:0] data_out_r,
	output reg data_ready_n,
	// status
	input wire status_read,
	output reg resync_flag,
	output reg secondary_fail_flag
);
	localparam integer BARRIER_INT = `BARRIER_CYCLES;
	localparam integer PULSE_INT = `READY_PULSE_CYCLES;
	localparam [7:0] BARRIER_CNT = BARRIER_INT[7:0];
	localparam [3:0] PULSE_CNT = PULSE_INT[3:0];

	// returns {channel, field}; channel 3 means no channel register
	function [4:0] cfg_decode;
		input [5:0] a;
		integer k;
		reg [5:0] d;
		begin
			cfg_decode = 5'h1F;
			for (k = 0; k < `NCH; k = k + 1) begin
				d = a - `CFG_BASE - (k[5:0] * `CH_STRIDE);
				if (d < `CH_STRIDE) begin
					cfg_decode = {k[1:0], d[2:0]};
				end
			end
		end
	endfunction

	function [23:0] sat24;
		input [25:0] v;
		begin
			if (!v[25] && (v[24] || v[23])) begin
				sat24 = `SAT_POS;
			end else if (v[25] && !(v[24] && v[23])) begin
				sat24 = `SAT_NEG;
			end else begin
				sat24 = v[23:0];
			end
		end
	endfunction

	// sample period timing
	reg mclk_d_r;
	reg sync_d_r;
	reg [9:0] period_cnt_r;
	wire tick = main_clock_in && !mclk_d_r;
	wire sync_fall = !sync_reset_n && sync_d_r;
	wire frame_end = tick && (period_cnt_r == `PERIOD_LAST);
	wire [4:0] dec = cfg_decode(cfg_addr);
	wire chan_write = cfg_write && (dec[4:3] != 2'h3);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mclk_d_r <= 1'b0;
			sync_d_r <= 1'b1;
			period_cnt_r <= 10'h000;
			resync_flag <= 1'b0;
		end else begin
			mclk_d_r <= main_clock_in;
			sync_d_r <= sync_reset_n;
			// an aligned edge leaves timing alone and starts nothing
			if (sync_fall && period_cnt_r != 10'h000) begin
				period_cnt_r <= 10'h000;
			end else if (tick) begin
				period_cnt_r <= period_cnt_r + 10'h001;
			end
			if (sync_fall && period_cnt_r != 10'h000) begin
				resync_flag <= 1'b1;
			end else if (status_read) begin
				resync_flag <= 1'b0;
			end
		end
	end

	// per-channel calibration and phase-shifted capture
	reg busy_r;
	wire [71:0] ofs_flat;
	wire [71:0] gain_flat;
	wire [71:0] frame_flat;
	genvar n;
	generate
		for (n = 0; n < `NCH; n = n + 1) begin : chan
			reg [23:0] ofs_r;
			reg [23:0] gain_r;
			reg [9:0] phase_r;
			reg [23:0] cap_r;
			reg [23:0] frame_r;
			wire [23:0] raw = raw_data[24*n+23:24*n];
			wire hit = tick && (period_cnt_r == phase_r);
			wire sel = cfg_write && (dec[4:3] == n);
			assign ofs_flat[24*n+23:24*n] = ofs_r;
			assign gain_flat[24*n+23:24*n] = gain_r;
			assign frame_flat[24*n+23:24*n] = frame_r;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					ofs_r <= `OFFSET_RESET;
					gain_r <= `GAIN_RESET;
					phase_r <= {`PHASE_W{1'b0}};
					cap_r <= 24'h000000;
					frame_r <= 24'h000000;
				end else begin
					if (sel && dec[2:0] == `F_OFS_UP) begin
						ofs_r[23:8] <= cfg_wdata;
					end
					if (sel && dec[2:0] == `F_OFS_LO) begin
						ofs_r[7:0] <= cfg_wdata[15:8];
					end
					if (sel && dec[2:0] == `F_GAIN_UP) begin
						gain_r[23:8] <= cfg_wdata;
					end
					if (sel && dec[2:0] == `F_GAIN_LO) begin
						gain_r[7:0] <= cfg_wdata[15:8];
					end
					// channel 0 is the zero-phase reference and keeps phase 0
					if (sel && dec[2:0] == `F_CFG && n != 0) begin
						phase_r <= cfg_wdata[`PHASE_MSB:`PHASE_LSB];
					end
					if (hit) begin
						cap_r <= raw;
					end
					if (frame_end && !busy_r) begin
						frame_r <= hit ? raw : cap_r;
					end
				end
			end
		end
	endgenerate

	// one shared corrector walks the three channels of a frame
	reg [1:0] eng_idx_r;
	wire [23:0] eng_raw = frame_flat[eng_idx_r*24 +: 24];
	wire [23:0] eng_ofs = ofs_flat[eng_idx_r*24 +: 24];
	wire [23:0] eng_gain = gain_flat[eng_idx_r*24 +: 24];
	wire [25:0] diff = {{2{eng_raw[23]}}, eng_raw} - {{2{eng_ofs[23]}}, eng_ofs};
	wire [23:0] ofs_corr = sat24(diff);
	wire signed [48:0] prod = $signed({{25{ofs_corr[23]}}, ofs_corr}) * $signed({25'h0000000, eng_gain});
	wire [23:0] corr = sat24(prod[`GAIN_FRAC+25:`GAIN_FRAC]);
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [23:0] fifo_out_data;

	// a frame finishing while the corrector is stalled is dropped
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_r <= 1'b0;
			eng_idx_r <= 2'h0;
		end else if (!busy_r) begin
			busy_r <= frame_end;
			eng_idx_r <= 2'h0;
		end else if (fifo_in_ready) begin
			eng_idx_r <= eng_idx_r + 2'h1;
			if (eng_idx_r == 2'h2) begin
				busy_r <= 1'b0;
			end
		end
	end

	sample_fifo #(
		.WIDTH(`DW),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(busy_r),
		.in_ready(fifo_in_ready),
		.in_data(corr),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// output buffer loader
	reg ld_busy_r;
	reg ld_keep_r;
	reg [1:0] ld_idx_r;
	reg skip_r;
	reg unread_r;
	reg [1:0] rd_idx_r;
	reg [3:0] pulse_cnt_r;
	reg [23:0] buf0_r;
	reg [23:0] buf1_r;
	reg [23:0] buf2_r;
	wire ld_start = !ld_busy_r && fifo_out_valid && (!unread_r || ready_pulse_format);
	wire ld_done = ld_busy_r && fifo_out_valid && ld_idx_r == 2'h2;
	wire last_read = word_read && unread_r && rd_idx_r == 2'h2;
	assign fifo_out_ready = ld_busy_r;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ld_busy_r <= 1'b0;
			ld_keep_r <= 1'b0;
			ld_idx_r <= 2'h0;
			skip_r <= 1'b0;
			buf0_r <= 24'h000000;
			buf1_r <= 24'h000000;
			buf2_r <= 24'h000000;
		end else if (ld_start) begin
			ld_busy_r <= 1'b1;
			ld_idx_r <= 2'h0;
			// unread with pulse format: drop one frame, keep the next
			ld_keep_r <= !unread_r || skip_r;
			skip_r <= unread_r && !skip_r;
		end else if (ld_busy_r && fifo_out_valid) begin
			ld_idx_r <= ld_idx_r + 2'h1;
			if (ld_idx_r == 2'h2) begin
				ld_busy_r <= 1'b0;
			end
			if (ld_keep_r) begin
				case (ld_idx_r)
					2'h0: buf0_r <= fifo_out_data;
					2'h1: buf1_r <= fifo_out_data;
					default: buf2_r <= fifo_out_data;
				endcase
			end
		end
	end

	// host reads; a load finishing with the last read wins
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unread_r <= 1'b0;
			rd_idx_r <= 2'h0;
			data_out_r <= 24'h000000;
			data_ready_n <= 1'b1;
			pulse_cnt_r <= 4'h0;
		end else begin
			if (word_read) begin
				case (rd_idx_r)
					2'h0: data_out_r <= buf0_r;
					2'h1: data_out_r <= buf1_r;
					default: data_out_r <= buf2_r;
				endcase
				rd_idx_r <= (rd_idx_r == 2'h2) ? 2'h0 : rd_idx_r + 2'h1;
			end
			if (ld_done && ld_keep_r) begin
				unread_r <= 1'b1;
				rd_idx_r <= 2'h0;
				data_ready_n <= 1'b0;
				pulse_cnt_r <= PULSE_CNT;
			end else begin
				if (last_read) begin
					unread_r <= 1'b0;
				end
				if (pulse_cnt_r != 4'h0) begin
					pulse_cnt_r <= pulse_cnt_r - 4'h1;
				end
				if (ready_pulse_format ? (pulse_cnt_r == 4'h1) : word_read) begin
					data_ready_n <= 1'b1;
				end
			end
		end
	end

	// secondary fail holds for the barrier transfer time after each channel register write
	reg [7:0] barrier_cnt_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			barrier_cnt_r <= 8'h00;
			secondary_fail_flag <= 1'b0;
		end else if (chan_write) begin
			barrier_cnt_r <= BARRIER_CNT;
			secondary_fail_flag <= 1'b1;
		end else if (barrier_cnt_r != 8'h00) begin
			barrier_cnt_r <= barrier_cnt_r - 8'h01;
			secondary_fail_flag <= (barrier_cnt_r != 8'h01);
		end
	end
endmodule
`default_nettype wire

// *** corr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module corr_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// watched inputs
	input wire logic cfg_write,
	input wire logic [5:0] cfg_addr,
	input wire logic sync_reset_n,
	input wire logic status_read,
	input wire logic word_read,
	input wire logic ready_pulse_format,
	// watched outputs
	input wire logic [23:0] data_out_r,
	input wire logic data_ready_n,
	input wire logic resync_flag,
	input wire logic secondary_fail_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// cycles since the last write, parked at 101 so it cannot wrap
	logic [7:0] cnt;
	// only channel register writes cross the barrier
	wire chan_wr = cfg_write && (cfg_addr >= 6'h09) && (cfg_addr <= 6'h17);
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			cnt <= 8'h00;
		else if (chan_wr)
			cnt <= 8'h01;
		else if (cnt != 8'h00 && cnt < 8'h65)
			cnt <= cnt + 8'h01;
	end
	AST_SECFAIL_SET: assert property (chan_wr |=> secondary_fail_flag) else $error("fail flag not set");
	AST_SECFAIL_SPAN: assert property (cnt != 8'h00 |-> secondary_fail_flag == (cnt <= 8'h64))
		else $error("fail flag span wrong");
	AST_RESYNC_SRC: assert property ($rose(resync_flag) |-> !$past(sync_reset_n) || !$past(sync_reset_n, 2))
		else $error("resync flag without sync fall");
	AST_RESYNC_CLR: assert property (status_read && sync_reset_n |=> !resync_flag)
		else $error("resync not cleared");
	AST_RESYNC_HOLD: assert property (resync_flag && !status_read |=> resync_flag)
		else $error("resync flag lost");
	AST_READY_LEVEL: assert property (!ready_pulse_format && !data_ready_n && !word_read |=> !data_ready_n)
		else $error("ready released without read");
	AST_READY_RISE: assert property (!ready_pulse_format && !data_ready_n && word_read |=> data_ready_n)
		else $error("ready not released by read");
	AST_READY_PULSE: assert property (ready_pulse_format && $fell(data_ready_n) |->
		(!data_ready_n)[*8] ##1 !data_ready_n ##1 !data_ready_n ##1 data_ready_n) else $error("ready pulse width");
	AST_DATA_STABLE: assert property (!word_read |=> $stable(data_out_r)) else $error("data changed unread");
endmodule
bind adc_result_correction_status corr_monitor corr_monitor_i (.clk(clk), .resetn(resetn), .cfg_write(cfg_write),
	.cfg_addr(cfg_addr),
	.sync_reset_n(sync_reset_n), .status_read(status_read), .word_read(word_read),
	.ready_pulse_format(ready_pulse_format), .data_out_r(data_out_r), .data_ready_n(data_ready_n),
	.resync_flag(resync_flag), .secondary_fail_flag(secondary_fail_flag));
`default_nettype wire

// *** host_reader.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_reader (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// request from the bench
	input wire logic start,
	input wire logic [1:0] n,
	// device side
	input wire logic [23:0] data_out_r,
	output logic word_read,
	// result
	output logic busy,
	output logic [71:0] words
);
	logic [1:0] ph;
	logic [1:0] left;
	// one word per three cycles: pulse, release, then sample the settled answer
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			word_read <= 1'b0;
			ph <= 2'h0;
			left <= 2'h0;
			words <= 72'h0;
		end else if (!busy) begin
			busy <= start;
			left <= n;
			ph <= 2'h0;
		end else begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			word_read <= (ph == 2'h0) && (left != 2'h0);
			if (ph == 2'h0 && left == 2'h0)
				busy <= 1'b0;
			if (ph == 2'h2) begin
				words <= {data_out_r, words[71:24]};
				left <= left - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, resetn, sync_reset_n, cfg_write, ready_pulse_format, word_read, status_read;
	logic main_clock_in = 1'b0;
	logic [71:0] raw_data, words;
	logic [5:0] cfg_addr;
	logic [15:0] cfg_wdata;
	logic [23:0] data_out_r;
	logic data_ready_n, resync_flag, secondary_fail_flag, start, busy, prev;
	logic [1:0] n;
	int num_errors = 0, total_checks = 0, i, falls;
	adc_result_correction_status adc_result_correction_status_i (.clk(clk), .resetn(resetn),
		.main_clock_in(main_clock_in), .sync_reset_n(sync_reset_n), .raw_data(raw_data), .cfg_write(cfg_write),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .ready_pulse_format(ready_pulse_format), .word_read(word_read),
		.data_out_r(data_out_r), .data_ready_n(data_ready_n), .status_read(status_read),
		.resync_flag(resync_flag), .secondary_fail_flag(secondary_fail_flag));
	host_reader host_reader_i (.clk(clk), .resetn(resetn), .start(start), .n(n), .data_out_r(data_out_r),
		.word_read(word_read), .busy(busy), .words(words));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// converter clock ticks every second cycle
	always @(negedge clk) main_clock_in <= ~main_clock_in;
	task test_done;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [71:0] got, input logic [71:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task fail_out;
		num_errors++;
		test_done;
	endtask
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge clk) cfg_addr = a;
		cfg_wdata = d;
		cfg_write = 1'b1;
		@(negedge clk) cfg_write = 1'b0;
		@(negedge clk) chk(secondary_fail_flag, 1);
		for (i = 0; i < 150 && secondary_fail_flag !== 1'b0; i++)
			@(negedge clk);
		if (i == 150) fail_out;
	endtask
	task wait_ready;
		for (i = 0; i < 5000 && data_ready_n !== 1'b0; i++)
			@(negedge clk);
		if (i == 5000) fail_out;
	endtask
	task rd(input logic [1:0] cnt);
		@(negedge clk) start = 1'b1;
		n = cnt;
		@(negedge clk) start = 1'b0;
		for (i = 0; i < 50 && busy !== 1'b0; i++)
			@(negedge clk);
		if (i == 50) fail_out;
	endtask
	task do_reset;
		resetn = 1'b0;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
	endtask
	initial begin
		{cfg_write, ready_pulse_format, status_read, start, cfg_addr, cfg_wdata, n} = '0;
		sync_reset_n = 1'b1;
		raw_data = {24'h7FFFF0, 24'h000100, 24'h000150};
		do_reset;
		chk({data_out_r, data_ready_n, resync_flag, secondary_fail_flag}, {24'h0, 3'b100});
		wr(6'h0B, 16'h5000);
		wr(6'h10, 16'h1000);
		wr(6'h11, 16'h4000);
		wr(6'h14, 16'hFFFF);
		wait_ready;
		rd(3);
		chk(words, {24'h7FFFFF, 24'h000078, 24'h000100});
		chk(data_ready_n, 1);
		// channel 1 samples mid-period from here on
		wr(6'h0E, 16'h8000);
		// partial read leaves the frame pending even as new samples arrive
		wait_ready;
		raw_data = {24'h000000, 24'h000300, 24'h000400};
		rd(2);
		repeat (4200) @(negedge clk);
		rd(1);
		chk(words[71:48], 24'h7FFFFF);
		// next frame: channels 0 and 2 were taken before the change, channel 1 after it
		wait_ready;
		rd(3);
		chk(words, {24'h7FFFFF, 24'h000178, 24'h000100});
		sync_reset_n = 1'b0;
		repeat (3) @(negedge clk);
		chk(resync_flag, 1);
		sync_reset_n = 1'b1;
		@(negedge clk) status_read = 1'b1;
		@(negedge clk) status_read = 1'b0;
		@(negedge clk) chk(resync_flag, 0);
		// unread pulse format: every second frame reaches the buffer
		ready_pulse_format = 1'b1;
		do_reset;
		falls = 0;
		prev = 1'b1;
		repeat (8 * 2048 + 200) begin
			@(negedge clk);
			if (prev === 1'b1 && data_ready_n === 1'b0) falls++;
			prev = data_ready_n;
		end
		chk(falls, 4);
		test_done;
	end
endmodule
`default_nettype wire
